// *** core/eem_core.sv ***
// Error enable mask register bank with error status flags,
// master clock counter and a level interrupt.
// Assumes error events come from logic on mclk_i, one bit per flag.
`timescale 1ns/1ps

module eem_core
    import eem_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [EEM_AW-1:0] addr_i,
    input wire logic [EEM_DW-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [EEM_DW-1:0] rd_data_o,
    // Error events and controls
    input wire logic [EEM_FLAG_W-1:0] err_event_i,
    output logic [EEM_FLAG_W-1:0] err_enable_o,
    output logic conv_check_run_o,
    output logic [EEM_DW-1:0] clk_count_o,
    // Interrupt
    output logic irq_o
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [EEM_EN_W-1:0] enable;
        logic [EEM_FLAG_W-1:0] flags;
        logic [EEM_DW-1:0] count;
        logic [EEM_IRQ_W-1:0] irq_stat;
        logic [EEM_IRQ_W-1:0] irq_en;
        logic [EEM_DW-1:0] rdata;
    } eem_state_t;

    eem_state_t s_q;
    eem_state_t s_d;

    logic wr_enable;
    logic wr_status;
    logic wr_irq_clr;
    logic wr_irq_en;
    logic [EEM_FLAG_W-1:0] flag_set;
    logic cnt_wrap;

    // -----------------------------------------------------------------
    // Decoding
    // -----------------------------------------------------------------
    // One strobe and one address compare, shared by every write decode.
    function automatic logic reg_hit(
        input logic strobe,
        input logic [EEM_AW-1:0] addr,
        input logic [EEM_AW-1:0] target
    );
        reg_hit = strobe && (addr == target);
    endfunction : reg_hit

    assign wr_enable = reg_hit(wr_i, addr_i, EEM_ADDR_ERR_ENABLE);
    assign wr_status = reg_hit(wr_i, addr_i, EEM_ADDR_ERR_STATUS);
    assign wr_irq_clr = reg_hit(wr_i, addr_i, EEM_ADDR_IRQ_CLEAR);
    assign wr_irq_en = reg_hit(wr_i, addr_i, EEM_ADDR_IRQ_ENABLE);

    // An event reaches its flag only through its enable bit.
    assign flag_set = err_event_i & s_q.enable[EEM_FLAG_W-1:0];
    assign cnt_wrap = s_q.enable[EEM_BIT_CNT_EN] && (&s_q.count);

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;
        if (wr_enable) begin
            // Reserved upper bits are simply not stored.
            s_d.enable = wr_data_i[EEM_EN_W-1:0];
        end
        // A new event in the clearing cycle wins over the clear.
        s_d.flags = s_q.flags;
        if (wr_status) begin
            s_d.flags = s_q.flags & ~wr_data_i[EEM_FLAG_W-1:0];
        end
        s_d.flags = s_d.flags | flag_set;
        if (s_q.enable[EEM_BIT_CNT_EN]) begin
            s_d.count = s_q.count + 16'h0001;
        end
        if (wr_irq_en) begin
            s_d.irq_en = wr_data_i[EEM_IRQ_W-1:0];
        end
        if (wr_irq_clr) begin
            s_d.irq_stat = s_q.irq_stat & ~wr_data_i[EEM_IRQ_W-1:0];
        end
        if (|flag_set) begin
            s_d.irq_stat[EEM_IRQ_ERR_FLAGGED] = 1'b1;
        end
        if (cnt_wrap) begin
            s_d.irq_stat[EEM_IRQ_CNT_WRAP] = 1'b1;
        end
        if (rd_i) begin
            unique case (addr_i)
                EEM_ADDR_ERR_ENABLE: s_d.rdata = {3'h0, s_q.enable};
                EEM_ADDR_ERR_STATUS: s_d.rdata = {4'h0, s_q.flags};
                EEM_ADDR_CLK_COUNT: s_d.rdata = s_q.count;
                EEM_ADDR_IRQ_STATUS: s_d.rdata = {14'h0000, s_q.irq_stat};
                EEM_ADDR_IRQ_ENABLE: s_d.rdata = {14'h0000, s_q.irq_en};
                default: s_d.rdata = '0;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_q.enable <= EEM_ENABLE_RESET[EEM_EN_W-1:0];
            s_q.flags <= EEM_FLAGS_RESET;
            s_q.count <= EEM_COUNT_RESET;
            s_q.irq_stat <= EEM_IRQ_RESET;
            s_q.irq_en <= EEM_IRQ_RESET;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data_o = s_q.rdata;
    assign err_enable_o = s_q.enable[EEM_FLAG_W-1:0];
    assign conv_check_run_o = s_q.enable[EEM_BIT_CONV_CHECK];
    assign clk_count_o = s_q.count;
    assign irq_o = |(s_q.irq_stat & s_q.irq_en);

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    // Helper: high until the first write to the enable register.
    logic untouched_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            untouched_q <= 1'b1;
        end else if (wr_enable) begin
            untouched_q <= 1'b0;
        end
    end

    a_flag_needs_enable: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ##1 ((s_q.flags & ~$past(s_q.flags) & ~$past(s_q.enable[EEM_FLAG_W-1:0])) == '0))
        else $error("Error flag set while its enable was clear.");

    a_enable_reset_val: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        untouched_q |-> ({3'h0, s_q.enable} == 16'h0040))
        else $error("Enable register left its reset value without a write.");

    a_wr_ignore_default: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        untouched_q |-> s_q.enable[EEM_BIT_WR_IGNORE])
        else $error("Write ignore check enable not set after reset.");

    a_count_runs: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_q.enable[EEM_BIT_CNT_EN] ##1 s_q.enable[EEM_BIT_CNT_EN]
        |-> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("Clock counter did not advance while enabled.");

    a_count_holds: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !s_q.enable[EEM_BIT_CNT_EN] |=> $stable(s_q.count))
        else $error("Clock counter moved while disabled.");

    a_pos_range_gate: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (!s_q.enable[EEM_BIT_POS_RANGE] && !s_q.flags[EEM_BIT_POS_RANGE])
        |=> !s_q.flags[EEM_BIT_POS_RANGE])
        else $error("Positive input range flag set while disabled.");

    a_conv_check_out: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_enable && wr_data_i[EEM_BIT_CONV_CHECK]) |=> conv_check_run_o)
        else $error("Conversion checks not running after enable write.");

    a_reserved_zero: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == EEM_ADDR_ERR_ENABLE) |=> rd_data_o[15:13] == 3'h0)
        else $error("Reserved enable bits read nonzero.");

    a_w1c_clears: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_status && wr_data_i[0] && !err_event_i[0]) |=> !s_q.flags[0])
        else $error("Write of one did not clear the status flag.");

    a_w0_keeps: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_status && !wr_data_i[1] && s_q.flags[1]) |=> s_q.flags[1])
        else $error("Write of zero cleared a status flag.");

    a_enable_readback: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_enable ##1 (rd_i && addr_i == EEM_ADDR_ERR_ENABLE && !wr_i)
        |=> rd_data_o == {3'h0, $past(wr_data_i[EEM_EN_W-1:0], 2)})
        else $error("Enable register did not read back the written value.");

    a_irq_level: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (err_event_i[2] && s_q.enable[2] && s_q.irq_en[EEM_IRQ_ERR_FLAGGED]) |=> irq_o)
        else $error("Interrupt not raised for an enabled error event.");

    // -----------------------------------------------------------------
    // Checks on the individual error gates
    // -----------------------------------------------------------------

    a_neg_range_gate: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (!s_q.enable[EEM_BIT_NEG_RANGE] && !s_q.flags[EEM_BIT_NEG_RANGE])
        |=> !s_q.flags[EEM_BIT_NEG_RANGE])
        else $error("Negative input range flag set while disabled.");

    a_ref_range_gate: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (!s_q.enable[EEM_BIT_REF_RANGE] && !s_q.flags[EEM_BIT_REF_RANGE])
        |=> !s_q.flags[EEM_BIT_REF_RANGE])
        else $error("Reference range flag set while disabled.");

    a_ref_detect_gate: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (!s_q.enable[EEM_BIT_REF_DETECT] && !s_q.flags[EEM_BIT_REF_DETECT])
        |=> !s_q.flags[EEM_BIT_REF_DETECT])
        else $error("Reference detect flag set while disabled.");

    a_conv_flag_gate: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (!s_q.enable[EEM_BIT_CONV_CHECK] && !s_q.flags[EEM_BIT_CONV_CHECK])
        |=> !s_q.flags[EEM_BIT_CONV_CHECK])
        else $error("Conversion flag set while disabled.");

    a_pos_range_sets: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (err_event_i[EEM_BIT_POS_RANGE] && s_q.enable[EEM_BIT_POS_RANGE])
        |=> s_q.flags[EEM_BIT_POS_RANGE])
        else $error("Enabled positive input range event was lost.");

    a_neg_range_sets: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (err_event_i[EEM_BIT_NEG_RANGE] && s_q.enable[EEM_BIT_NEG_RANGE])
        |=> s_q.flags[EEM_BIT_NEG_RANGE])
        else $error("Enabled negative input range event was lost.");

    a_ref_range_sets: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (err_event_i[EEM_BIT_REF_RANGE] && s_q.enable[EEM_BIT_REF_RANGE])
        |=> s_q.flags[EEM_BIT_REF_RANGE])
        else $error("Enabled reference range event was lost.");

    a_ref_detect_sets: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (err_event_i[EEM_BIT_REF_DETECT] && s_q.enable[EEM_BIT_REF_DETECT])
        |=> s_q.flags[EEM_BIT_REF_DETECT])
        else $error("Enabled reference detect event was lost.");

    a_conv_flag_sets: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (err_event_i[EEM_BIT_CONV_CHECK] && s_q.enable[EEM_BIT_CONV_CHECK])
        |=> s_q.flags[EEM_BIT_CONV_CHECK])
        else $error("Enabled conversion event was lost.");

    a_conv_check_stop: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_enable && !wr_data_i[EEM_BIT_CONV_CHECK]) |=> !conv_check_run_o)
        else $error("Conversion checks still running after disable write.");

    a_flag_event_irq: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (|(err_event_i & s_q.enable[EEM_FLAG_W-1:0]))
        |=> s_q.irq_stat[EEM_IRQ_ERR_FLAGGED])
        else $error("Enabled error event did not mark the interrupt status.");

    a_set_beats_clear: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_status && wr_data_i[3] && err_event_i[3] && s_q.enable[3]) |=> s_q.flags[3])
        else $error("Clear won over an event in the same cycle.");

    // -----------------------------------------------------------------
    // Checks on the register port
    // -----------------------------------------------------------------

    a_reserved_unstored: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_enable |=> s_q.enable == $past(wr_data_i[EEM_EN_W-1:0]))
        else $error("Enable register did not store the written bits.");

    a_err_enable_follows: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_enable |=> err_enable_o == $past(wr_data_i[EEM_FLAG_W-1:0]))
        else $error("Error enable outputs do not follow the write.");

    a_wr_ignore_keep: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_enable && wr_data_i[EEM_BIT_WR_IGNORE]) |=> err_enable_o[EEM_BIT_WR_IGNORE])
        else $error("Write ignore check enable lost after a write of one.");

    a_enable_readval: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == EEM_ADDR_ERR_ENABLE) |=> rd_data_o == {3'h0, $past(s_q.enable)})
        else $error("Enable register read returned a wrong value.");

    a_status_readback: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == EEM_ADDR_ERR_STATUS) |=> rd_data_o == {4'h0, $past(s_q.flags)})
        else $error("Status register read returned a wrong value.");

    a_count_readback: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == EEM_ADDR_CLK_COUNT) |=> rd_data_o == $past(s_q.count))
        else $error("Counter register read returned a wrong value.");

    a_irq_stat_readback: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == EEM_ADDR_IRQ_STATUS)
        |=> rd_data_o == {14'h0000, $past(s_q.irq_stat)})
        else $error("Interrupt status read returned a wrong value.");

    a_unmapped_read: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i > EEM_ADDR_IRQ_ENABLE) |=> rd_data_o == '0)
        else $error("Unmapped address read returned nonzero data.");

    a_rdata_idle: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rd_i |=> rd_data_o == '0)
        else $error("Read data stood outside its cycle.");

    a_count_wrap_irq: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (s_q.enable[EEM_BIT_CNT_EN] && (&s_q.count)) |=> s_q.irq_stat[EEM_IRQ_CNT_WRAP])
        else $error("Counter wrap did not mark the interrupt status.");

    a_irq_clear_works: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (wr_irq_clr && wr_data_i[EEM_IRQ_ERR_FLAGGED] && !(|flag_set))
        |=> !s_q.irq_stat[EEM_IRQ_ERR_FLAGGED])
        else $error("Interrupt status bit survived its clear.");

endmodule : eem_core

// *** inc/eem_pkg.sv ***
// Constants for the error enable mask register bank.
// Assumes one core clock domain and a plain register port.
package eem_pkg;

    // -----------------------------------------------------------------
    // Widths
    // -----------------------------------------------------------------
    localparam int EEM_AW = 8;
    localparam int EEM_DW = 16;
    localparam int EEM_FLAG_W = 12;
    localparam int EEM_EN_W = 13;
    localparam int EEM_IRQ_W = 2;

    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] EEM_ADDR_ERR_STATUS = 8'h06;
    localparam logic [7:0] EEM_ADDR_ERR_ENABLE = 8'h07;
    localparam logic [7:0] EEM_ADDR_CLK_COUNT = 8'h08;
    localparam logic [7:0] EEM_ADDR_IRQ_STATUS = 8'h09;
    localparam logic [7:0] EEM_ADDR_IRQ_CLEAR = 8'h0A;
    localparam logic [7:0] EEM_ADDR_IRQ_ENABLE = 8'h0B;

    // -----------------------------------------------------------------
    // Field positions in the enable register
    // -----------------------------------------------------------------
    localparam int EEM_BIT_CNT_EN = 12;
    localparam int EEM_BIT_POS_RANGE = 11;
    localparam int EEM_BIT_NEG_RANGE = 10;
    localparam int EEM_BIT_REF_RANGE = 9;
    localparam int EEM_BIT_REF_DETECT = 8;
    localparam int EEM_BIT_CONV_CHECK = 7;
    localparam int EEM_BIT_WR_IGNORE = 6;

    // Interrupt status bit positions.
    localparam int EEM_IRQ_ERR_FLAGGED = 0;
    localparam int EEM_IRQ_CNT_WRAP = 1;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [15:0] EEM_ENABLE_RESET = 16'h0040;
    localparam logic [11:0] EEM_FLAGS_RESET = 12'h000;
    localparam logic [15:0] EEM_COUNT_RESET = 16'h0000;
    localparam logic [1:0] EEM_IRQ_RESET = 2'h0;

endpackage : eem_pkg

// *** test/eem_core_test.sv ***
// Self-checking bench for the error enable mask register bank.
// Assumes eem_pkg is compiled first; the bench drives every core input itself.
`timescale 1ns/1ps

module eem_core_test import eem_pkg::*; ();

    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [EEM_AW-1:0] addr_i = 8'h00;
    logic [EEM_DW-1:0] wr_data_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [EEM_DW-1:0] rd_data_o;
    logic [EEM_FLAG_W-1:0] err_event_i = 12'h000;
    logic [EEM_FLAG_W-1:0] err_enable_o;
    logic conv_check_run_o;
    logic [EEM_DW-1:0] clk_count_o;
    logic irq_o;
    int err_count = 0;
    int n_compared = 0;
    logic [15:0] v;
    logic [15:0] d;
    logic [15:0] c;
    logic [11:0] e;
    logic [11:0] ev;
    logic [11:0] clr;

    always #50 mclk_i = ~mclk_i;

    eem_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .err_event_i(err_event_i),
        .err_enable_o(err_enable_o), .conv_check_run_o(conv_check_run_o),
        .clk_count_o(clk_count_o), .irq_o(irq_o));

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        wr_data_i <= dat;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [7:0] a, output logic [15:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        dat = rd_data_o;
    endtask : rd

    // Write then read the same register with no idle cycle between strobes.
    task automatic wrrd(input logic [7:0] a, input logic [15:0] dat, output logic [15:0] back);
        @(posedge mclk_i);
        addr_i <= a;
        wr_data_i <= dat;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        back = rd_data_o;
    endtask : wrrd

    task automatic pulse(input logic [11:0] bits);
        @(posedge mclk_i);
        err_event_i <= bits;
        @(posedge mclk_i);
        err_event_i <= 12'h000;
        #1;
    endtask : pulse

    task automatic print_verdict;
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // -----------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        void'($urandom(71));
        #1;
        chk({4'h0, err_enable_o}, 16'h0040);
        chk({15'h0, conv_check_run_o}, 16'h0000);
        rd(EEM_ADDR_ERR_ENABLE, v);
        chk(v, 16'h0040);
        rd(8'h3F, v);
        chk(v, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom) & 16'hEFFF;
            if (i % 2 == 1) begin
                wrrd(EEM_ADDR_ERR_ENABLE, d, v);
            end else begin
                wr(EEM_ADDR_ERR_ENABLE, d);
                rd(EEM_ADDR_ERR_ENABLE, v);
            end
            chk(v, d & 16'h1FFF);
            @(posedge mclk_i);
            #1 chk(rd_data_o, 16'h0000);
            chk({4'h0, err_enable_o}, {4'h0, d[11:0]});
            chk({15'h0, conv_check_run_o}, {15'h0, d[7]});
        end
        // Enables bounce around while flags are raised and cleared.
        for (int i = 0; i < 10; i++) begin
            e = 12'($urandom);
            ev = 12'($urandom);
            clr = 12'($urandom);
            if (i == 0) e = 12'h000;
            if (i == 1) begin
                e = 12'hF80;
                ev = 12'hF80;
            end
            wr(EEM_ADDR_ERR_ENABLE, {4'h0, e});
            wr(EEM_ADDR_ERR_STATUS, 16'h0FFF);
            pulse(ev);
            rd(EEM_ADDR_ERR_STATUS, v);
            chk(v, {4'h0, ev & e});
            wr(EEM_ADDR_ERR_STATUS, {4'h0, clr});
            rd(EEM_ADDR_ERR_STATUS, v);
            chk(v, {4'h0, ev & e & ~clr});
        end
        // An event that lands on the clearing write must survive it.
        wr(EEM_ADDR_ERR_ENABLE, 16'h0008);
        wr(EEM_ADDR_ERR_STATUS, 16'h0FFF);
        @(posedge mclk_i);
        err_event_i <= 12'h008;
        wr(EEM_ADDR_ERR_STATUS, 16'h0FFF);
        err_event_i <= 12'h000;
        rd(EEM_ADDR_ERR_STATUS, v);
        chk(v, 16'h0008);
        wr(EEM_ADDR_ERR_ENABLE, 16'h1000);
        repeat (2) @(posedge mclk_i);
        #1 c = clk_count_o;
        repeat (50) @(posedge mclk_i);
        #1 chk(clk_count_o, c + 16'd50);
        wr(EEM_ADDR_ERR_ENABLE, 16'h0800);
        #1 c = clk_count_o;
        repeat (20) @(posedge mclk_i);
        #1 chk(clk_count_o, c);
        rd(EEM_ADDR_CLK_COUNT, v);
        chk(v, c);
        wr(EEM_ADDR_IRQ_ENABLE, 16'h0001);
        pulse(12'h800);
        chk({15'h0, irq_o}, 16'h0001);
        rd(EEM_ADDR_IRQ_STATUS, v);
        chk(v, 16'h0001);
        wr(EEM_ADDR_IRQ_ENABLE, 16'h0000);
        #1 chk({15'h0, irq_o}, 16'h0000);
        wr(EEM_ADDR_IRQ_ENABLE, 16'h0001);
        #1 chk({15'h0, irq_o}, 16'h0001);
        wr(EEM_ADDR_IRQ_CLEAR, 16'h0001);
        #1 chk({15'h0, irq_o}, 16'h0000);
        // A full wrap of the counter is the only way to raise the second source.
        wr(EEM_ADDR_IRQ_ENABLE, 16'h0002);
        wr(EEM_ADDR_ERR_ENABLE, 16'h1000);
        for (int k = 0; k < 66000 && irq_o !== 1'b1; k++) @(posedge mclk_i);
        #1 chk({15'h0, irq_o}, 16'h0001);
        rd(EEM_ADDR_IRQ_STATUS, v);
        chk(v, 16'h0002);
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge mclk_i);
        err_count++;
        print_verdict();
    end

endmodule : eem_core_test
